// ### mgf_pkg.sv
package mgf_pkg;

   localparam int NUM_PINS = 8;
   localparam int NUM_MONS = 12;

   // Register offsets
   localparam logic [7:0] OFS_PIN_INPUT  = 8'h1e;
   localparam logic [7:0] OFS_ALM1_MONS  = 8'h36;
   localparam logic [7:0] OFS_ALM1_CTRL  = 8'h37;
   localparam logic [7:0] OFS_ALM2_MONS  = 8'h38;
   localparam logic [7:0] OFS_ALM2_CTRL  = 8'h39;
   localparam logic [7:0] OFS_OC_DEP     = 8'h3a;
   localparam logic [7:0] OFS_PIN_OUTPUT = 8'h3e;
   localparam logic [7:0] OFS_FUNC_A     = 8'h3f;
   localparam logic [7:0] OFS_FUNC_B     = 8'h40;
   localparam logic [7:0] OFS_FUNC_C     = 8'h41;
   localparam logic [7:0] OFS_DRIVE      = 8'h42;

   // Fields of the second dependency register of each alarm
   localparam int CTRL_MON_HI_W = 4;
   localparam int CTRL_OV_BIT   = 4;
   localparam int CTRL_UV_BIT   = 5;
   localparam int CTRL_EW_BIT   = 6;
   localparam int CTRL_POL_BIT  = 7;
   // Fields of the overcurrent dependency register
   localparam int OC_ALM1_BIT   = 0;
   localparam int OC_ALM2_BIT   = 1;
   localparam logic [7:0] OC_DEP_MASK = 8'h03;

   localparam int FUNC_W = 3;

   // Reset values, used until the flash image is loaded
   localparam logic [7:0] RST_REG = 8'h00;

   // Pins carrying each pin-specific function
   localparam logic [7:0] PINS_PHASE  = 8'h84;
   localparam logic [7:0] PINS_RST2   = 8'ha2;
   localparam logic [7:0] PINS_MR     = 8'h55;
   localparam logic [7:0] PINS_WDI    = 8'h01;
   localparam logic [7:0] PINS_EXT    = 8'h88;
   localparam logic [7:0] PINS_EN2    = 8'h50;
   localparam logic [7:0] PINS_MARGIN = 8'h20;

   localparam logic [2:0] FN_INPUT  = 3'h0;
   localparam logic [2:0] FN_OUTPUT = 3'h1;
   localparam logic [2:0] FN_ALM2   = 3'h2;
   localparam logic [2:0] FN_ALM1   = 3'h3;
   localparam logic [2:0] FN_RESET  = 3'h4;
   localparam logic [2:0] FN_OVERCURRENT_INDICATOR  = 3'h5;
   localparam logic [2:0] FN_MR_WD  = 3'h6;
   localparam logic [2:0] FN_SPEC   = 3'h7;

   typedef enum logic [3:0] {
      ROLE_IN, ROLE_OUT, ROLE_ALM1, ROLE_ALM2, ROLE_PHASE, ROLE_ANY,
      ROLE_RST2, ROLE_OVERCURRENT_INDICATOR, ROLE_MR, ROLE_WDO, ROLE_WDI, ROLE_EXT,
      ROLE_EN2, ROLE_MARGIN
   } mgf_role_e;

   // Threshold events of the monitored supply inputs
   typedef struct packed {
      logic [NUM_MONS-1:0] ov;
      logic [NUM_MONS-1:0] uv;
      logic [NUM_MONS-1:0] ew;
   } mgf_mon_s;

   // Power-up defaults held in the flash shadow
   typedef struct packed {
      logic [7:0] alm1_mons;
      logic [7:0] alm1_ctrl;
      logic [7:0] alm2_mons;
      logic [7:0] alm2_ctrl;
      logic [7:0] oc_dep;
      logic [7:0] pin_output;
      logic [7:0] func_a;
      logic [7:0] func_b;
      logic [7:0] func_c;
      logic [7:0] drive;
   } mgf_flash_s;

   // Active-high events from the rest of the device
   typedef struct packed {
      logic sequence_phase_alarm;
      logic any_fault;
      logic secondary_reset_out;
      logic overcurrent_indicator;
      logic watchdog_expiry_out;
      logic external_alarm_drive;
   } mgf_sys_in_s;

   // Pin-derived signals handed to the rest of the device
   typedef struct packed {
      logic manual_reset_in_n;
      logic watchdog_kick_in;
      logic secondary_sequence_enable;
      logic margin_in_n;
      logic external_alarm_in_n;
   } mgf_sys_out_s;

endpackage

// ### mgf_pin_sync.sv
`timescale 1ns/1ps
module mgf_pin_sync
   import mgf_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
   wire  [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // Idle pull-up level, so no false low follows reset
         stage1 <= '1;
         stage2 <= '1;
         stage3 <= '1;
         level  <= '1;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         level  <= next_level;
      end
   end

endmodule // mgf_pin_sync

// ### mgf_gpio_top.sv
`timescale 1ns/1ps
//Behaviour
// - Pin levels readable, output values writable
// - Flash shadow sets output power-up defaults
// - Any pin can drive alarm two; all but pins 2 and 7 can drive alarm one
// - Alarms follow monitor events and overcurrent
// - Alarm dependencies held in five registers
// - Alarm is OR of selected monitor events
// - Alarms independent of critical-fault mechanism
// - Drive-type bit per pin: push-pull/open-drain
// - Top control bit sets alarm pin polarity; first/second_programmable_alarm outputs stay active high
// - Separate enables for ov, uv, ew thresholds
// - Overcurrent register bits feed alarm one, two
module mgf_gpio_top
   import mgf_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   output logic      [7:0]    reg_rdata,
   input  wire mgf_flash_s    flash_image,
   input  wire mgf_mon_s      monitored_supply_input,
   input  wire logic          secondary_overcurrent,
   input  wire mgf_sys_in_s   sys_in,
   output mgf_sys_out_s       sys_out,
   output logic               first_programmable_alarm,
   output logic               second_programmable_alarm,
   input  wire logic [7:0]    pin_in,
   output logic      [7:0]    pin_out,
   output logic      [7:0]    pin_oe
);

   // Role of one pin from its function code and position
   function automatic mgf_role_e pin_role(input logic [2:0] code,
                                          input int idx);
      mgf_role_e r;
      r = ROLE_IN;
      case (code)
         FN_INPUT:  r = ROLE_IN;
         FN_OUTPUT: r = ROLE_OUT;
         FN_ALM2:   r = ROLE_ALM2;
         FN_ALM1:   r = PINS_PHASE[idx] ? ROLE_PHASE : ROLE_ALM1;
         FN_RESET:  r = PINS_RST2[idx] ? ROLE_RST2 : ROLE_ANY;
         FN_OVERCURRENT_INDICATOR:  r = ROLE_OVERCURRENT_INDICATOR;
         FN_MR_WD:  r = PINS_MR[idx] ? ROLE_MR : ROLE_WDO;
         FN_SPEC: begin
            if (PINS_WDI[idx])
               r = ROLE_WDI;
            else if (PINS_EXT[idx])
               r = ROLE_EXT;
            else if (PINS_EN2[idx])
               r = ROLE_EN2;
            else if (PINS_MARGIN[idx])
               r = ROLE_MARGIN;
            else
               r = ROLE_IN;
         end
         default:   r = ROLE_IN;
      endcase
      return r;
   endfunction

   // Raw alarm from the dependency registers
   function automatic logic alarm_raw(input logic [7:0] mons,
                                      input logic [7:0] ctrl,
                                      input logic       oc_en,
                                      input mgf_mon_s   mon,
                                      input logic       oc);
      logic [NUM_MONS-1:0] sel;
      logic [NUM_MONS-1:0] hit;
      sel = {ctrl[CTRL_MON_HI_W-1:0], mons};
      hit = (mon.ov & {NUM_MONS{ctrl[CTRL_OV_BIT]}})
          | (mon.uv & {NUM_MONS{ctrl[CTRL_UV_BIT]}})
          | (mon.ew & {NUM_MONS{ctrl[CTRL_EW_BIT]}});
      return (|(sel & hit)) | (oc_en & oc);
   endfunction

   logic [7:0] alm1_mons;
   logic [7:0] alm1_ctrl;
   logic [7:0] alm2_mons;
   logic [7:0] alm2_ctrl;
   logic [7:0] oc_dep;
   logic [7:0] pin_output;
   logic [7:0] func_a;
   logic [7:0] func_b;
   logic [7:0] func_c;
   logic [7:0] drive;
   logic       load_pending;
   logic [7:0] pin_level;

   mgf_pin_sync #(
      .WIDTH (NUM_PINS)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (pin_in),
      .level    (pin_level)
   );

   // Register decode
   wire wr_alm1_mons  = reg_wr && reg_addr == OFS_ALM1_MONS;
   wire wr_alm1_ctrl  = reg_wr && reg_addr == OFS_ALM1_CTRL;
   wire wr_alm2_mons  = reg_wr && reg_addr == OFS_ALM2_MONS;
   wire wr_alm2_ctrl  = reg_wr && reg_addr == OFS_ALM2_CTRL;
   wire wr_oc_dep     = reg_wr && reg_addr == OFS_OC_DEP;
   wire wr_pin_output = reg_wr && reg_addr == OFS_PIN_OUTPUT;
   wire wr_func_a     = reg_wr && reg_addr == OFS_FUNC_A;
   wire wr_func_b     = reg_wr && reg_addr == OFS_FUNC_B;
   wire wr_func_c     = reg_wr && reg_addr == OFS_FUNC_C;
   wire wr_drive      = reg_wr && reg_addr == OFS_DRIVE;

   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         OFS_PIN_INPUT:  rd_mux = pin_level;
         OFS_ALM1_MONS:  rd_mux = alm1_mons;
         OFS_ALM1_CTRL:  rd_mux = alm1_ctrl;
         OFS_ALM2_MONS:  rd_mux = alm2_mons;
         OFS_ALM2_CTRL:  rd_mux = alm2_ctrl;
         OFS_OC_DEP:     rd_mux = oc_dep;
         OFS_PIN_OUTPUT: rd_mux = pin_output;
         OFS_FUNC_A:     rd_mux = func_a;
         OFS_FUNC_B:     rd_mux = func_b;
         OFS_FUNC_C:     rd_mux = func_c;
         OFS_DRIVE:      rd_mux = drive;
         default:        rd_mux = 8'h00;
      endcase
   end

   // Flash image copied once, one cycle after reset release
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         load_pending <= 1'b1;
         alm1_mons    <= RST_REG;
         alm1_ctrl    <= RST_REG;
         alm2_mons    <= RST_REG;
         alm2_ctrl    <= RST_REG;
         oc_dep       <= RST_REG;
         pin_output   <= RST_REG;
         func_a       <= RST_REG;
         func_b       <= RST_REG;
         func_c       <= RST_REG;
         drive        <= RST_REG;
      end else if (load_pending) begin
         load_pending <= 1'b0;
         alm1_mons    <= flash_image.alm1_mons;
         alm1_ctrl    <= flash_image.alm1_ctrl;
         alm2_mons    <= flash_image.alm2_mons;
         alm2_ctrl    <= flash_image.alm2_ctrl;
         oc_dep       <= flash_image.oc_dep & OC_DEP_MASK;
         pin_output   <= flash_image.pin_output;
         func_a       <= flash_image.func_a;
         func_b       <= flash_image.func_b;
         func_c       <= flash_image.func_c;
         drive        <= flash_image.drive;
      end else begin
         if (wr_alm1_mons)
            alm1_mons <= reg_wdata;
         if (wr_alm1_ctrl)
            alm1_ctrl <= reg_wdata;
         if (wr_alm2_mons)
            alm2_mons <= reg_wdata;
         if (wr_alm2_ctrl)
            alm2_ctrl <= reg_wdata;
         if (wr_oc_dep)
            oc_dep <= reg_wdata & OC_DEP_MASK;
         if (wr_pin_output)
            pin_output <= reg_wdata;
         if (wr_func_a)
            func_a <= reg_wdata;
         if (wr_func_b)
            func_b <= reg_wdata;
         if (wr_func_c)
            func_c <= reg_wdata;
         if (wr_drive)
            drive <= reg_wdata;
      end
   end

   // Alarms use only monitor events and overcurrent; no critical-fault input exists
   wire alm1_raw = alarm_raw(alm1_mons, alm1_ctrl, oc_dep[OC_ALM1_BIT],
                             monitored_supply_input,
                             secondary_overcurrent);
   wire alm2_raw = alarm_raw(alm2_mons, alm2_ctrl, oc_dep[OC_ALM2_BIT],
                             monitored_supply_input,
                             secondary_overcurrent);
   wire alm1_lvl = alm1_ctrl[CTRL_POL_BIT] ? alm1_raw : ~alm1_raw;
   wire alm2_lvl = alm2_ctrl[CTRL_POL_BIT] ? alm2_raw : ~alm2_raw;

   wire [23:0] func_codes = {func_c, func_b, func_a};

   // Per-pin drive value, drive request and input claims
   logic [7:0] want_level;
   logic [7:0] want_drive;
   logic [7:0] is_mr;
   logic [7:0] is_wdi;
   logic [7:0] is_en2;
   logic [7:0] is_margin;
   logic [7:0] is_ext;

   always_comb begin
      mgf_role_e role;
      role       = ROLE_IN;
      want_level = '0;
      want_drive = '0;
      is_mr      = '0;
      is_wdi     = '0;
      is_en2     = '0;
      is_margin  = '0;
      is_ext     = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         role = pin_role(func_codes[FUNC_W*i +: FUNC_W], i);
         case (role)
            ROLE_OUT: begin
               want_level[i] = pin_output[i];
               want_drive[i] = 1'b1;
            end
            ROLE_ALM1: begin
               want_level[i] = alm1_lvl;
               want_drive[i] = 1'b1;
            end
            ROLE_ALM2: begin
               want_level[i] = alm2_lvl;
               want_drive[i] = 1'b1;
            end
            ROLE_PHASE: begin
               want_level[i] = ~sys_in.sequence_phase_alarm;
               want_drive[i] = 1'b1;
            end
            ROLE_ANY: begin
               want_level[i] = ~(sys_in.any_fault | alm1_raw | alm2_raw);
               want_drive[i] = 1'b1;
            end
            ROLE_RST2: begin
               want_level[i] = ~sys_in.secondary_reset_out;
               want_drive[i] = 1'b1;
            end
            ROLE_OVERCURRENT_INDICATOR: begin
               want_level[i] = ~sys_in.overcurrent_indicator;
               want_drive[i] = 1'b1;
            end
            ROLE_WDO: begin
               want_level[i] = ~sys_in.watchdog_expiry_out;
               want_drive[i] = 1'b1;
            end
            ROLE_EXT: begin
               // Drives low only while the device reports a fault
               want_level[i] = 1'b0;
               want_drive[i] = sys_in.external_alarm_drive;
               is_ext[i]     = 1'b1;
            end
            ROLE_MR:     is_mr[i]     = 1'b1;
            ROLE_WDI:    is_wdi[i]    = 1'b1;
            ROLE_EN2:    is_en2[i]    = 1'b1;
            ROLE_MARGIN: is_margin[i] = 1'b1;
            default: begin
               want_level[i] = 1'b0;
               want_drive[i] = 1'b0;
            end
         endcase
      end
   end

   // Open drain drives only the low level
   wire [7:0] next_oe  = want_drive & (~drive | ~want_level);
   wire [7:0] next_out = want_level & ~drive;

   // Pin-derived signals, idle levels when no pin is assigned
   wire next_mr_n   = ~|(is_mr & ~pin_level);
   wire next_wdi    = |(is_wdi & pin_level);
   wire next_en2    = |(is_en2 & pin_level);
   wire next_marg_n = ~|(is_margin & ~pin_level);
   wire next_ext_n  = ~|(is_ext & ~pin_level);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata                 <= 8'h00;
         pin_out                   <= 8'h00;
         pin_oe                    <= 8'h00;
         first_programmable_alarm  <= 1'b0;
         second_programmable_alarm <= 1'b0;
         sys_out                   <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      end else begin
         if (reg_rd)
            reg_rdata <= rd_mux;
         pin_out                   <= next_out;
         pin_oe                    <= next_oe;
         first_programmable_alarm  <= alm1_raw;
         second_programmable_alarm <= alm2_raw;
         sys_out.manual_reset_in_n         <= next_mr_n;
         sys_out.watchdog_kick_in          <= next_wdi;
         sys_out.secondary_sequence_enable <= next_en2;
         sys_out.margin_in_n               <= next_marg_n;
         sys_out.external_alarm_in_n       <= next_ext_n;
      end
   end

endmodule // mgf_gpio_top

// ### mgf_gpio_props.sv
`timescale 1ns/1ps
module mgf_gpio_props
   import mgf_pkg::*;
(
   input wire logic         sys_clk,
   input wire logic         rst_n,
   input wire logic         reg_wr,
   input wire logic         reg_rd,
   input wire logic [7:0]   reg_addr,
   input wire logic [7:0]   reg_wdata,
   input wire logic [7:0]   reg_rdata,
   input wire mgf_flash_s   flash_image,
   input wire mgf_mon_s     monitored_supply_input,
   input wire logic         secondary_overcurrent,
   input wire mgf_sys_in_s  sys_in,
   input wire mgf_sys_out_s sys_out,
   input wire logic         first_programmable_alarm,
   input wire logic         second_programmable_alarm,
   input wire logic [7:0]   pin_in,
   input wire logic [7:0]   pin_out,
   input wire logic [7:0]   pin_oe
);
   logic       ld;
   logic [7:0] s [13];
   logic [7:0] lv;
   logic [7:0] mk;

   function automatic logic alm(logic [7:0] m, logic [7:0] c, logic oc,
                                mgf_mon_s v, logic so);
      logic [11:0] sel;
      sel = {c[3:0], m};
      return |(sel & ((v.ov & {12{c[4]}}) | (v.uv & {12{c[5]}})
              | (v.ew & {12{c[6]}}))) | (oc & so);
   endfunction

   wire        rw     = reg_addr inside {[8'h36:8'h3a], [8'h3e:8'h42]};
   wire        mapped = rw || reg_addr == OFS_PIN_INPUT;
   wire [23:0] fn     = {s[11], s[10], s[9]};
   wire        e1     = alm(s[0], s[1], s[4][0], monitored_supply_input,
                            secondary_overcurrent);
   wire        e2     = alm(s[2], s[3], s[4][1], monitored_supply_input,
                            secondary_overcurrent);
   wire [7:0]  xoe    = ~s[12] | ~lv;
   wire [7:0]  xout   = ~s[12] & lv;

   // Shadow of the writable registers, flash copied after reset
   always_ff @(posedge sys_clk) begin
      ld <= !rst_n;
      if (!rst_n) begin
         for (int i = 0; i < 13; i++)
            s[i] <= RST_REG;
      end else if (ld) begin
         for (int i = 0; i < 10; i++)
            s[i < 5 ? i : i + 3] <= flash_image[79-8*i -: 8];
      end else if (reg_wr && rw) begin
         s[reg_addr - 8'h36] <= reg_wdata;
      end
   end

   always_comb begin
      for (int n = 0; n < 8; n++) begin
         mk[n] = 1'b1;
         lv[n] = 1'b0;
         case (fn[3*n +: 3])
            FN_OUTPUT: lv[n] = s[8][n];
            FN_ALM2:   lv[n] = e2 ~^ s[3][7];
            FN_ALM1: begin
               lv[n] = e1 ~^ s[1][7];
               mk[n] = (n != 2) && (n != 7);
            end
            default:   mk[n] = 1'b0;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_alarm1;
      first_programmable_alarm == $past(e1);
   endproperty
   property p_alarm2;
      second_programmable_alarm == $past(e2);
   endproperty
   property p_pin_drive;
      (pin_oe & $past(mk)) == $past(xoe & mk)
      && (pin_out & $past(mk)) == $past(xout & mk);
   endproperty
   property p_rd_hold;
      !$past(reg_rd) |-> $stable(reg_rdata);
   endproperty
   property p_unmapped;
      reg_rd && !mapped |=> reg_rdata == 8'h00;
   endproperty
   property p_oc_rsv;
      reg_rd && reg_addr == OFS_OC_DEP |=> reg_rdata[7:2] == 6'h00;
   endproperty
   property p_wr_rd;
      reg_wr && rw && !ld ##1 reg_rd && !reg_wr && $stable(reg_addr)
      |=> reg_rdata == ($past(reg_wdata, 2) &
          ($past(reg_addr) == OFS_OC_DEP ? OC_DEP_MASK : 8'hff));
   endproperty
   property p_in_rd;
      $stable(pin_in) [*6] ##0 (reg_rd && reg_addr == OFS_PIN_INPUT)
      |=> reg_rdata == $past(pin_in);
   endproperty

   a_alarm1:    assert property (p_alarm1) else $error("alarm1 wrong");
   a_alarm2:    assert property (p_alarm2) else $error("alarm2 wrong");
   a_pin_drive: assert property (p_pin_drive) else $error("pin bad");
   a_rd_hold:   assert property (p_rd_hold) else $error("rdata moved");
   a_unmapped:  assert property (p_unmapped) else $error("unmapped");
   a_oc_rsv:    assert property (p_oc_rsv) else $error("oc bits");
   a_wr_rd:     assert property (p_wr_rd) else $error("readback");
   a_in_rd:     assert property (p_in_rd) else $error("pin level");

   c_alarm1: cover property ($rose(first_programmable_alarm));
   c_od_low: cover property (|(pin_oe & ~pin_out & s[12]));
   c_in_rd:  cover property (reg_rd && reg_addr == OFS_PIN_INPUT);
endmodule // mgf_gpio_props

bind mgf_gpio_top mgf_gpio_props u_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .flash_image(flash_image),
   .monitored_supply_input(monitored_supply_input),
   .secondary_overcurrent(secondary_overcurrent), .sys_in(sys_in),
   .sys_out(sys_out), .first_programmable_alarm(first_programmable_alarm),
   .second_programmable_alarm(second_programmable_alarm),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
);

// ### mgf_board.sv
`timescale 1ns/1ps
module mgf_board
   import mgf_pkg::*;
(
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] drv,
   input  wire logic [7:0] drv_oe,
   output logic      [7:0] level
);
   // Pull-up holds undriven pins high
   assign level = (pin_oe & pin_out) | (~pin_oe & drv_oe & drv)
                | (~pin_oe & ~drv_oe);
endmodule // mgf_board

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
   import mgf_pkg::*;
;
   logic         sys_clk = 0;
   logic         rst_n = 0;
   logic         reg_wr = 0;
   logic         reg_rd = 0;
   logic         soc = 0;
   logic [7:0]   reg_addr = 0;
   logic [7:0]   reg_wdata = 0;
   logic [7:0]   bdrv = 0;
   logic [7:0]   bdoe = 0;
   mgf_flash_s   fl = '0;
   mgf_mon_s     mon = '0;
   mgf_sys_in_s  si = '0;
   mgf_sys_out_s so;
   logic         a1;
   logic         a2;
   logic [7:0]   reg_rdata;
   logic [7:0]   pin_out;
   logic [7:0]   pin_oe;
   logic [7:0]   pin_lvl;
   logic [7:0]   mr [256];
   logic [31:0]  seed = 5665;
   int           err_total = 0;
   int           n_compared = 0;
   int           rw_q[$] = '{'h36, 'h37, 'h38, 'h39, 'h3a,
                             'h3e, 'h3f, 'h40, 'h41, 'h42};

   always #25 sys_clk = ~sys_clk;

   mgf_gpio_top dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .flash_image(fl), .monitored_supply_input(mon),
      .secondary_overcurrent(soc), .sys_in(si), .sys_out(so),
      .first_programmable_alarm(a1), .second_programmable_alarm(a2),
      .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe)
   );
   mgf_board brd (.pin_out(pin_out), .pin_oe(pin_oe), .drv(bdrv),
                  .drv_oe(bdoe), .level(pin_lvl));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d, bit rb = 1'b0);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      if (a inside {[8'h36:8'h3a], [8'h3e:8'h42]})
         mr[a] = (a == OFS_OC_DEP) ? d & OC_DEP_MASK : d;
      // Optional read-back in the very next cycle
      if (rb) begin
         reg_rd <= 1'b1;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         #1;
         chk("reg_rdata", reg_rdata, mr[a]);
      end
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, e);
   endtask

   task automatic set_fn(logic [23:0] f);
      wr(OFS_FUNC_A, f[7:0]);
      wr(OFS_FUNC_B, f[15:8]);
      wr(OFS_FUNC_C, f[23:16]);
   endtask

   function automatic logic malm(int k);
      logic [11:0] sel;
      logic [7:0]  c;
      logic        r;
      c = mr[8'h37 + 2*k];
      sel = {c[3:0], mr[8'h36 + 2*k]};
      r = mr[8'h3a][k] & soc;
      for (int i = 0; i < 12; i++)
         r |= sel[i] & (mon.ov[i] & c[4] | mon.uv[i] & c[5]
                        | mon.ew[i] & c[6]);
      return r;
   endfunction

   task automatic chk_pins();
      logic [23:0] f;
      logic [2:0]  c;
      logic        l;
      logic        od;
      #1;
      f = {mr[8'h41], mr[8'h40], mr[8'h3f]};
      for (int n = 0; n < 8; n++) begin
         c = f[3*n +: 3];
         od = mr[8'h42][n];
         l = (c == FN_OUTPUT) ? mr[8'h3e][n] : (c == FN_ALM2) ?
             malm(1) ~^ mr[8'h39][7] : malm(0) ~^ mr[8'h37][7];
         if (c inside {FN_OUTPUT, FN_ALM2} || c == FN_ALM1 && n % 5 != 2)
         begin
            chk("pin_oe", pin_oe[n], od ? !l : 1'b1);
            chk("pin_out", pin_out[n], od ? 1'b0 : l);
         end
      end
   endtask

   task automatic chk_spec(logic [2:0] c);
      logic [7:0] eo;
      logic [7:0] ed;
      logic [7:0] lv;
      logic [7:0] m;
      logic [4:0] es;
      logic       w;
      logic       s7;
      #1;
      for (int n = 0; n < 8; n++) begin
         ed[n] = 1'b1;
         case (c)
            FN_ALM1:  w = PINS_PHASE[n] ? !si.sequence_phase_alarm
                                        : malm(0) ~^ mr[8'h37][7];
            FN_RESET: w = PINS_RST2[n] ? !si.secondary_reset_out
                          : !(si.any_fault | malm(0) | malm(1));
            FN_OVERCURRENT_INDICATOR: w = !si.overcurrent_indicator;
            FN_MR_WD: begin
               w = !si.watchdog_expiry_out;
               ed[n] = !PINS_MR[n];
            end
            default: begin
               w = 1'b0;
               ed[n] = PINS_EXT[n] & si.external_alarm_drive;
            end
         endcase
         eo[n] = w & ed[n] & !mr[8'h42][n];
         ed[n] = ed[n] & (!mr[8'h42][n] | !w);
      end
      lv = (ed & eo) | (~ed & bdrv);
      m  = (c == FN_MR_WD) ? PINS_MR : 8'h00;
      s7 = (c == FN_SPEC);
      es = {~|(m & ~lv), s7 & |(PINS_WDI & lv), s7 & |(PINS_EN2 & lv),
            !(s7 & |(PINS_MARGIN & ~lv)), !(s7 & |(PINS_EXT & ~lv))};
      chk("pin_oe", pin_oe, ed);
      chk("pin_out", pin_out, eo);
      chk("sys_out", so, es);
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      fl = 80'({rnd(), rnd(), rnd()});
      {fl.func_c, fl.func_b, fl.func_a} = {8{FN_OUTPUT}};
      for (int i = 0; i < 10; i++)
         mr[rw_q[i]] = fl[79-8*i -: 8];
      mr[8'h3a] &= OC_DEP_MASK;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      foreach (rw_q[i]) rd(rw_q[i], mr[rw_q[i]]);
      chk_pins();
      $display("flash defaults test done");
      foreach (rw_q[i]) begin
         wr(rw_q[i], 8'(rnd()), 1'b1);
         rd(rw_q[i], mr[rw_q[i]]);
      end
      wr(8'h3c, 8'hff);
      wr(OFS_PIN_INPUT, 8'hff);
      rd(8'h3c, 8'h00);
      $display("register test done");
      set_fn(24'h0);
      repeat (4) begin
         bdoe <= 8'hff;
         bdrv <= 8'(rnd());
         repeat (6) @(posedge sys_clk);
         rd(OFS_PIN_INPUT, bdrv);
      end
      bdoe <= 8'h00;
      set_fn({8{FN_OUTPUT}});
      repeat (6) begin
         wr(OFS_PIN_OUTPUT, 8'(rnd()));
         wr(OFS_DRIVE, 8'(rnd()));
         repeat (6) @(posedge sys_clk);
         chk_pins();
         rd(OFS_PIN_INPUT, mr[8'h3e]);
      end
      $display("output test done");
      // Pins 2 and 7 kept off code 011, which is their phase alarm
      set_fn({FN_ALM2, FN_ALM1, FN_ALM2, FN_ALM1, FN_ALM1, FN_ALM2, FN_ALM2,
              FN_ALM1});
      repeat (40) begin
         for (int i = 0; i < 6; i++)
            wr(i < 5 ? rw_q[i] : OFS_DRIVE, 8'(rnd()));
         mon <= 36'({rnd(), rnd()});
         soc <= 1'(rnd());
         si <= 6'(rnd());
         repeat (2) @(posedge sys_clk);
         chk_pins();
         chk("alarm1", a1, malm(0));
         chk("alarm2", a2, malm(1));
      end
      $display("alarm test done");
      // Pin-specific functions, board driving every pin
      bdoe <= 8'hff;
      for (int c = 3; c < 8; c++) begin
         set_fn({8{3'(c)}});
         repeat (2) begin
            si <= 6'(rnd());
            bdrv <= 8'(rnd());
            wr(OFS_DRIVE, 8'(rnd()));
            repeat (8) @(posedge sys_clk);
            chk_spec(3'(c));
         end
      end
      $display("pin function test done");
      tally_and_finish();
   end
endmodule // tb_top
